// ===== rtl/mcw_change_det.sv
// one source: pin synchroniser and status change detector
`timescale 1ns/1ps
module mcw_change_det (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic pin,
	output logic change
);
	logic meta_q;
	logic meta_d;
	logic sync_q;
	logic sync_d;
	logic last_q;
	logic last_d;
	logic [2:0] fill_q;
	logic [2:0] fill_d;

	// two flops, then compare against previous level
	always_comb begin
		meta_d = pin;
		sync_d = meta_q;
		last_d = sync_q;
		fill_d = {fill_q[1:0], 1'b1};
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
			fill_q <= 3'h0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			last_q <= last_d;
			fill_q <= fill_d;
		end
	end

	// silent until last_q holds a real sample: a pin idling high
	// must not look like an edge right after reset
	assign change = (sync_q ^ last_q) & fill_q[2];
endmodule

// ===== rtl/mcw_config_wake.sv
// configuration register with status change wake detection
`timescale 1ns/1ps
`include "mcw_map.svh"
// Summary of operation
// - bit 0 shows boot (0) or downloaded firmware (1) context.
// - wake interrupt when wake clock mask set and enabled pin changes.
// - the pin causing the wake is recorded as wake reason.
// - bits 5..2 enable pins a, b, card detect one, two.
// - power-up or watchdog reset clears the whole register.
// - usb reset leaves the register untouched.
module mcw_config_wake #(
	parameter int NUM_SRC = `MCW_NUM_SRC
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic watchdog_timer_reset,
	input wire logic usb_reset,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	output logic sfr_rvalid,
	input wire logic wake_clock_mask,
	input wire logic port_pin_a,
	input wire logic port_pin_b,
	input wire logic card_detect_one_pin_n,
	input wire logic card_detect_two_pin_n,
	output logic application_mode_flag,
	output logic wake_irq,
	output logic [3:0] wake_reason,
	output logic wake_reason_valid
);
	// source vectors are four bits wide; refuse any other count
	if (NUM_SRC != `MCW_NUM_SRC) begin : g_bad_num_src
		$error("mcw_config_wake: NUM_SRC must be 4");
	end

	mcw_pkg::mcw_byte_t cfg_q;
	mcw_pkg::mcw_byte_t cfg_d;
	mcw_pkg::mcw_byte_t rdata_q;
	mcw_pkg::mcw_byte_t rdata_d;
	logic rvalid_q;
	logic rvalid_d;
	logic irq_q;
	logic irq_d;
	mcw_pkg::mcw_src_t reason_q;
	mcw_pkg::mcw_src_t reason_d;
	logic rvld_q;
	logic rvld_d;
	mcw_pkg::mcw_src_t change;
	mcw_pkg::mcw_src_t pins;
	mcw_pkg::mcw_src_t enables;
	mcw_pkg::mcw_src_t hit;
	logic sel;

	assign pins = {card_detect_two_pin_n, card_detect_one_pin_n,
		port_pin_b, port_pin_a};

	// one detector per source
	genvar gi;
	generate
		for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
			mcw_change_det u_det (
				.core_clk(core_clk),
				.reset(reset),
				.pin(pins[gi]),
				.change(change[gi])
			);
		end
	endgenerate

	assign sel = (sfr_addr == `MCW_CFG_ADDR);
	assign enables = cfg_q[`MCW_BIT_EN_HI:`MCW_BIT_EN_LO];
	assign hit = change & enables & {4{wake_clock_mask}};

	// register write, watchdog clear; usb reset has no effect
	always_comb begin
		cfg_d = cfg_q;
		if (watchdog_timer_reset)
			cfg_d = `MCW_CFG_RESET;
		else if (sfr_wr && sel)
			cfg_d = sfr_wdata & `MCW_CFG_WMASK;
	end

	// configuration flops; usb_reset is deliberately never read here
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			cfg_q <= `MCW_CFG_RESET;
		end else begin
			cfg_q <= cfg_d;
		end
	end

	// read port, reserved bits zero, other addresses read zero
	always_comb begin
		rdata_d = 8'h00;
		if (sfr_rd && sel) begin
			rdata_d = cfg_q;
		end
		rvalid_d = sfr_rd;
	end

	// read data and valid stand for one cycle after the strobe
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	// wake pulse and reason capture; a watchdog reset drops a pending
	// wake so that no pulse ever comes out with a cleared reason
	always_comb begin
		irq_d = (|hit) && !watchdog_timer_reset;
		reason_d = reason_q;
		rvld_d = rvld_q;
		if (watchdog_timer_reset) begin
			reason_d = 4'h0;
			rvld_d = 1'b0;
		end else if (|hit) begin
			reason_d = hit;
			rvld_d = 1'b1;
		end
	end

	// wake flops
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			irq_q <= 1'b0;
			reason_q <= 4'h0;
			rvld_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
			reason_q <= reason_d;
			rvld_q <= rvld_d;
		end
	end

	// every output straight from a flop
	assign sfr_rdata = rdata_q;
	assign sfr_rvalid = rvalid_q;
	assign application_mode_flag = cfg_q[`MCW_BIT_APP];
	assign wake_irq = irq_q;
	assign wake_reason = reason_q;
	assign wake_reason_valid = rvld_q;

	// register contents
	reserved_zero_a: assert property (@(posedge core_clk)
		disable iff (reset) (cfg_q & ~`MCW_CFG_WMASK) == 8'h00)
		else $error("reserved bit set");
	wdt_clears_a: assert property (@(posedge core_clk)
		disable iff (reset) watchdog_timer_reset |=> cfg_q == 8'h00)
		else $error("watchdog did not clear");
	usb_keeps_a: assert property (@(posedge core_clk)
		disable iff (reset) usb_reset && !watchdog_timer_reset &&
		!(sfr_wr && sel) |=> $stable(cfg_q))
		else $error("usb reset changed register");
	app_flag_a: assert property (@(posedge core_clk)
		disable iff (reset) sfr_wr && sel && !watchdog_timer_reset |=>
		application_mode_flag == $past(sfr_wdata[0]))
		else $error("flag not written");
	enable_wr_a: assert property (@(posedge core_clk)
		disable iff (reset) sfr_wr && sel && !watchdog_timer_reset |=>
		enables == $past(sfr_wdata[5:2]))
		else $error("enables not written");

	// read path
	rd_value_a: assert property (@(posedge core_clk)
		disable iff (reset) sfr_rd && sel |=> sfr_rdata == $past(cfg_q))
		else $error("read data wrong");
	rd_other_a: assert property (@(posedge core_clk)
		disable iff (reset) sfr_rd && !sel |=> sfr_rdata == 8'h00)
		else $error("other address read not zero");
	rvalid_hi_a: assert property (@(posedge core_clk)
		disable iff (reset) sfr_rd |=> sfr_rvalid)
		else $error("read valid missing");
	rvalid_lo_a: assert property (@(posedge core_clk)
		disable iff (reset) !sfr_rd |=> !sfr_rvalid)
		else $error("read valid without read");

	// wake path
	wake_fires_a: assert property (@(posedge core_clk)
		disable iff (reset) (|(change & enables)) && wake_clock_mask &&
		!watchdog_timer_reset |=> wake_irq)
		else $error("wake missed");
	wake_gated_a: assert property (@(posedge core_clk)
		disable iff (reset) !wake_clock_mask |=> !wake_irq)
		else $error("wake without mask");
	wake_blocked_a: assert property (@(posedge core_clk)
		disable iff (reset) (change & enables) == 4'h0 |=> !wake_irq)
		else $error("wake from disabled source");
	reason_log_a: assert property (@(posedge core_clk)
		disable iff (reset) wake_irq |-> wake_reason != 4'h0 &&
		(wake_reason & ~$past(enables)) == 4'h0 && wake_reason_valid)
		else $error("bad reason");
	reason_hold_a: assert property (@(posedge core_clk)
		disable iff (reset) !wake_clock_mask && !watchdog_timer_reset |=>
		$stable(wake_reason))
		else $error("reason changed without wake");
	reason_sticky_a: assert property (@(posedge core_clk)
		disable iff (reset) wake_reason_valid && !watchdog_timer_reset |=>
		wake_reason_valid)
		else $error("reason valid dropped");
	wdt_reason_a: assert property (@(posedge core_clk)
		disable iff (reset) watchdog_timer_reset |=>
		!wake_reason_valid && !wake_irq && wake_reason == 4'h0)
		else $error("watchdog left a wake");

	// main scenarios
	cover_wake_c: cover property (@(posedge core_clk) wake_irq);
	cover_cd_both_c: cover property (@(posedge core_clk)
		cfg_q[5:4] == 2'b11 && wake_irq);
	cover_usb_c: cover property (@(posedge core_clk)
		usb_reset && cfg_q[0]);
	cover_wdt_c: cover property (@(posedge core_clk)
		watchdog_timer_reset && cfg_q != 8'h00);
	cover_rd_c: cover property (@(posedge core_clk)
		sfr_rvalid && sfr_rdata[0]);
endmodule

// ===== rtl/mcw_map.svh
// register offset, bit positions and reset values of the configuration block
`ifndef MCW_MAP_SVH
`define MCW_MAP_SVH
`define MCW_CFG_ADDR 8'hFC
`define MCW_CFG_RESET 8'h00
`define MCW_CFG_WMASK 8'h3D
`define MCW_BIT_APP 0
`define MCW_BIT_EN_LO 2
`define MCW_BIT_EN_HI 5
`define MCW_NUM_SRC 4
`endif

// ===== rtl/mcw_pkg.sv
// types shared by the configuration and wake detect block
package mcw_pkg;
	typedef logic [7:0] mcw_byte_t;
	typedef logic [3:0] mcw_src_t;
endpackage

// ===== tb/mcw_pin_model.sv
// pin model: port and card detect pins toggled on request
`timescale 1ns/1ps
module mcw_pin_model (
	input wire logic core_clk,
	input wire logic [3:0] flip,
	output logic [3:0] pins
);
	// card detect pins idle high (active low), port pins low
	logic [3:0] level_q = 4'hC;
	// a requested pin flips once, otherwise it holds
	always @(posedge core_clk) begin
		level_q <= level_q ^ flip;
	end
	assign pins = level_q;
endmodule

// ===== tb/test_mcu_config_wake.sv
// bench of the configuration register and wake detection
`timescale 1ns/1ps
module test_mcu_config_wake_detect;
	logic core_clk = 0, reset = 1, wd = 0, usb = 0, wr = 0, rd = 0, msk = 0;
	logic [7:0] addr = 8'hFC, wdat = 8'h00, rdat;
	logic rv, app, irq, rvld;
	logic [3:0] rsn, pins, flip = 4'h0;
	int n_fail = 0, check_count = 0;
	logic [7:0] rows [4][2] = '{'{8'hFF, 8'h3D}, '{8'h01, 8'h01},
		'{8'hC2, 8'h00}, '{8'h3C, 8'h3C}};
	always #2.5 core_clk = ~core_clk;
	mcw_pin_model mcw_pin_model_i (.core_clk(core_clk), .flip(flip),
		.pins(pins));
	mcw_config_wake mcw_config_wake_i (.core_clk(core_clk), .reset(reset),
		.watchdog_timer_reset(wd), .usb_reset(usb), .sfr_wr(wr),
		.sfr_rd(rd), .sfr_addr(addr), .sfr_wdata(wdat), .sfr_rdata(rdat),
		.sfr_rvalid(rv), .wake_clock_mask(msk), .port_pin_a(pins[0]),
		.port_pin_b(pins[1]), .card_detect_one_pin_n(pins[2]),
		.card_detect_two_pin_n(pins[3]), .application_mode_flag(app),
		.wake_irq(irq), .wake_reason(rsn), .wake_reason_valid(rvld));
	task chk(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// one write or read cycle; read data is settled on return
	task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		wr = w;
		rd = !w;
		addr = a;
		wdat = d;
		@(negedge core_clk);
		wr = 0;
		rd = 0;
	endtask
	// flip pin i, then look for a wake pulse over eight cycles
	task wake(input int i, input logic exp_hit);
		logic hit;
		hit = 0;
		@(negedge core_clk);
		flip = 4'h1 << i;
		@(negedge core_clk);
		flip = 4'h0;
		repeat (8) begin
			@(negedge core_clk);
			if (irq === 1'b1) begin
				hit = 1;
				chk({4'h0, rsn}, 8'h01 << i);
			end
		end
		chk({7'h0, hit}, {7'h0, exp_hit});
	endtask
	task end_sim;
		$display("checks %0d failures %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// cut a hang short
	initial begin
		#20000;
		n_fail++;
		end_sim;
	end
	initial begin
		repeat (16) @(negedge core_clk);
		reset = 0;
		acc(0, 8'hFC, 8'h00);
		chk(rdat, 8'h00);
		foreach (rows[i]) begin
			acc(1, 8'hFC, rows[i][0]);
			acc(0, 8'hFC, 8'h00);
			chk(rdat, rows[i][1]);
			chk({7'h0, rv}, 8'h01);
		end
		acc(1, 8'hFB, 8'h00);
		acc(0, 8'hFC, 8'h00);
		chk(rdat, 8'h3C);
		acc(0, 8'hFB, 8'h00);
		chk(rdat, 8'h00);
		$display("register test done");
		acc(1, 8'hFC, 8'h3D); // boot sets the flag
		chk({7'h0, app}, 8'h01);
		msk = 1;
		for (int i = 0; i < 4; i++) wake(i, 1);
		chk({7'h0, rvld}, 8'h01);
		msk = 0;
		wake(0, 0);
		msk = 1;
		acc(1, 8'hFC, 8'h01);
		wake(3, 0);
		$display("wake test done");
		usb = 1;
		repeat (4) @(negedge core_clk);
		acc(0, 8'hFC, 8'h00);
		chk(rdat, 8'h01);
		usb = 0;
		wd = 1;
		@(negedge core_clk);
		wd = 0;
		acc(0, 8'hFC, 8'h00);
		chk(rdat, 8'h00);
		chk({7'h0, app}, 8'h00);
		chk({7'h0, rvld}, 8'h00);
		$display("reset test done");
		// power-up reset in mid-run, with pins b and cd2 high
		acc(1, 8'hFC, 8'h3D);
		reset = 1;
		repeat (2) @(negedge core_clk);
		chk({6'h0, app, rvld}, 8'h00);
		reset = 0;
		acc(1, 8'hFC, 8'h3D); // enables land while detectors refill
		repeat (8) begin
			@(negedge core_clk);
			chk({7'h0, irq}, 8'h00);
		end
		$display("power-up reset test done");
		end_sim;
	end
endmodule
